// ---- src/pam_pkg.sv ----
// Contract
// RULE1: Mask resets 0x2000; advisory bit 13 sticky RW.
// RULE2: Sticky RW masks at 12,8,7,6,0; rest zero.
// RULE3: Bit 7 reads one; bit 8 sticky check enable.
// RULE4: Bit 5 reads one; bit 6 sticky generate enable.
// RULE5: Bits 4:0 hold sticky first error pointer.
// RULE6: Header bits 127:64 logged at 0x11c, 0x120.
// RULE7: Bad DLLP raised when DLLP CRCs differ.
// RULE8: Masked error recorded but not signalled upstream.
//
// Package: register map, field layout, reset values of the error block.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package pam_pkg;
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int PTR_W = 5;
  localparam int HDR_W = 64;
  localparam int CRC_W = 16;
  localparam int IRQ_W = 3;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_COR_MASK = 12'h114;
  localparam logic [ADR_W-1:0] OFS_CAP_CTRL = 12'h118;
  localparam logic [ADR_W-1:0] OFS_HDR_LOG0 = 12'h11c;
  localparam logic [ADR_W-1:0] OFS_HDR_LOG1 = 12'h120;
  localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 12'h140;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 12'h144;

  // Correctable error mask layout
  localparam int BIT_RX_ERR = 0;
  localparam int BIT_BAD_TLP = 6;
  localparam int BIT_BAD_DLLP = 7;
  localparam int BIT_REPLAY_ROLL = 8;
  localparam int BIT_REPLAY_TMO = 12;
  localparam int BIT_ADVISORY = 13;
  localparam logic [DAT_W-1:0] COR_MASK_WR = 32'h0000_31c1;
  localparam logic [DAT_W-1:0] COR_MASK_RST = 32'h0000_2000;

  // Capabilities and control layout
  localparam int BIT_GEN_CAP = 5;
  localparam int BIT_GEN_EN = 6;
  localparam int BIT_CHK_CAP = 7;
  localparam int BIT_CHK_EN = 8;
  localparam logic [DAT_W-1:0] CAP_CTRL_WR = 32'h0000_0140;
  localparam logic [DAT_W-1:0] CAP_CTRL_RO1 = 32'h0000_00a0;
  localparam logic [DAT_W-1:0] CAP_CTRL_RST = 32'h0000_00a0;

  // Interrupt status bits
  localparam int IRQ_COR_SIG = 0;
  localparam int IRQ_BAD_DLLP = 1;
  localparam int IRQ_HDR_CAP = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
endpackage

// ---- src/pam_req_if.sv ----
// Interface: one register request from the bus slave to the register core.
// Assumes both ends sit on clk_i; req is a one-cycle pulse.
`timescale 1ns/100ps
interface pam_req_if;
  import pam_pkg::*;
  logic req;
  logic we;
  logic [ADR_W-1:0] adr;
  logic [SEL_W-1:0] sel;
  logic [DAT_W-1:0] wdat;
  logic [DAT_W-1:0] rdat;
  modport bus (output req, output we, output adr, output sel, output wdat, input rdat);
  modport core (input req, input we, input adr, input sel, input wdat, output rdat);
endinterface

// ---- src/pam_wb_slave.sv ----
// Classic Wishbone slave front end: one ack per cycle of cyc and stb.
// Assumes the master holds its request until it samples ack.
`timescale 1ns/100ps
module pam_wb_slave
  import pam_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  pam_req_if.bus rq
);
  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
  } pam_wb_st_t;

  pam_wb_st_t st_reg;
  pam_wb_st_t st_next;
  logic take;

  // Accept once per request; ack drops in the cycle after it is given
  assign take = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign rq.req = take;
  assign rq.we = wb_we_i;
  assign rq.adr = wb_adr_i;
  assign rq.sel = wb_sel_i;
  assign rq.wdat = wb_dat_i;

  // Read data is latched with the ack so it stays steady in that cycle
  always_comb begin
    st_next = st_reg;
    st_next.ack = take;
    if (take && !wb_we_i) begin
      st_next.dat = rq.rdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;
endmodule

// ---- src/pam_err_regs.sv ----
// Correctable error mask, ECRC control, first error pointer and header log.
// Assumes status and severity registers live outside and feed the capture
// strobe; rst_sticky_i is the cold reset, rst_i the ordinary one.
`timescale 1ns/100ps
module pam_err_regs
  import pam_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rst_sticky_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [DAT_W-1:0] cor_err_i,
  input wire logic dllp_valid_i,
  input wire logic [CRC_W-1:0] dllp_crc_calc_i,
  input wire logic [CRC_W-1:0] dllp_crc_rx_i,
  input wire logic capture_i,
  input wire logic [PTR_W-1:0] capture_bit_i,
  input wire logic [HDR_W-1:0] capture_hdr_i,
  input wire logic log_release_i,
  output logic [DAT_W-1:0] cor_err_detect_o,
  output logic [DAT_W-1:0] cor_err_signal_o,
  output logic crc_check_enable_o,
  output logic crc_generate_enable_o,
  output logic irq_o
);
  typedef struct packed {
    logic [DAT_W-1:0] mask;
    logic [DAT_W-1:0] ctl;
    logic [PTR_W-1:0] ptr;
    logic [DAT_W-1:0] hdr0;
    logic [DAT_W-1:0] hdr1;
    logic held;
    logic [DAT_W-1:0] detect;
    logic [DAT_W-1:0] signal;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
  } pam_st_t;

  localparam pam_st_t ST_RESET = '{
    mask: COR_MASK_RST,
    ctl: CAP_CTRL_RST & CAP_CTRL_WR,
    ptr: '0,
    hdr0: '0,
    hdr1: '0,
    held: 1'b0,
    detect: '0,
    signal: '0,
    irq_stat: '0,
    irq_mask: IRQ_MASK_RST
  };

  pam_st_t st_reg;
  pam_st_t st_next;
  pam_req_if rq();
  logic bad_dllp;
  logic [DAT_W-1:0] cor_now;
  logic wr_hit;
  logic rd_hit;
  logic [DAT_W-1:0] rd_val;

  // Merge write data into writable bits of enabled byte lanes only
  function automatic logic [DAT_W-1:0] wr_merge(
    input logic [DAT_W-1:0] old,
    input logic [DAT_W-1:0] wdat,
    input logic [SEL_W-1:0] sel,
    input logic [DAT_W-1:0] wmask
  );
    logic [DAT_W-1:0] lane;
    lane = '0;
    for (int i = 0; i < SEL_W; i++) begin
      lane[i*8 +: 8] = {8{sel[i]}};
    end
    return (old & ~(lane & wmask)) | (wdat & lane & wmask);
  endfunction

  pam_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i || rst_sticky_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rq(rq.bus)
  );

  // DLLP CRC compare; a mismatch is a bad link packet
  assign bad_dllp = dllp_valid_i && (dllp_crc_calc_i != dllp_crc_rx_i); // [RULE7]
  assign cor_now = (cor_err_i | (DAT_W'(bad_dllp) << BIT_BAD_DLLP)) & COR_MASK_WR;
  assign wr_hit = rq.req && rq.we;
  assign rd_hit = rq.req && !rq.we;

  // Read mux; constant capability bits are not storage, so they cannot be lost
  always_comb begin
    unique case (rq.adr)
      OFS_COR_MASK: rd_val = st_reg.mask & COR_MASK_WR; // [RULE1] [RULE2]
      OFS_CAP_CTRL: rd_val = (st_reg.ctl & CAP_CTRL_WR) | CAP_CTRL_RO1 |
                             DAT_W'(st_reg.ptr); // [RULE3] [RULE4] [RULE5]
      OFS_HDR_LOG0: rd_val = st_reg.hdr0; // [RULE6]
      OFS_HDR_LOG1: rd_val = st_reg.hdr1; // [RULE6]
      OFS_IRQ_STAT: rd_val = DAT_W'(st_reg.irq_stat);
      OFS_IRQ_MASK: rd_val = DAT_W'(st_reg.irq_mask);
      default: rd_val = '0; // Unmapped reads as zero
    endcase
  end
  assign rq.rdat = rd_val;

  // Next state: writes, error detection, header capture, interrupt flags
  always_comb begin
    st_next = st_reg;
    // Writable controls, byte-lane aware; mask and ctl are sticky, irq_mask is not
    if (wr_hit && rq.adr == OFS_COR_MASK) begin
      st_next.mask = wr_merge(st_reg.mask, rq.wdat, rq.sel, COR_MASK_WR); // [RULE1] [RULE2]
    end
    if (wr_hit && rq.adr == OFS_CAP_CTRL) begin
      st_next.ctl = wr_merge(st_reg.ctl, rq.wdat, rq.sel, CAP_CTRL_WR); // [RULE3] [RULE4]
    end
    if (wr_hit && rq.adr == OFS_IRQ_MASK) begin
      st_next.irq_mask = IRQ_W'(wr_merge(DAT_W'(st_reg.irq_mask), rq.wdat, rq.sel,
                                         DAT_W'({IRQ_W{1'b1}})));
    end
    // Status is recorded whatever the mask; only upstream signalling is gated
    st_next.detect = cor_now; // [RULE8]
    st_next.signal = cor_now & ~st_reg.mask; // [RULE8]
    // First uncorrectable error freezes pointer and header until released
    if (capture_i && !st_reg.held) begin
      st_next.ptr = capture_bit_i; // [RULE5]
      st_next.hdr0 = capture_hdr_i[HDR_W-1 -: DAT_W]; // [RULE6]
      st_next.hdr1 = capture_hdr_i[DAT_W-1:0]; // [RULE6]
      st_next.held = 1'b1;
    end else if (log_release_i) begin
      st_next.held = 1'b0;
    end
    // Read clears the flags, a same-cycle event wins over the clear
    if (rd_hit && rq.adr == OFS_IRQ_STAT) begin
      st_next.irq_stat = '0;
    end
    if (|(cor_now & ~st_reg.mask)) begin
      st_next.irq_stat[IRQ_COR_SIG] = 1'b1;
    end
    if (bad_dllp) begin
      st_next.irq_stat[IRQ_BAD_DLLP] = 1'b1;
    end
    if (capture_i && !st_reg.held) begin
      st_next.irq_stat[IRQ_HDR_CAP] = 1'b1;
    end
    // Ordinary reset spares the sticky fields
    if (rst_i) begin
      st_next.held = ST_RESET.held;
      st_next.detect = ST_RESET.detect;
      st_next.signal = ST_RESET.signal;
      st_next.irq_stat = ST_RESET.irq_stat;
      st_next.irq_mask = ST_RESET.irq_mask;
    end
  end

  // Cold reset restores everything, sticky fields included
  always_ff @(posedge clk_i) begin
    if (rst_sticky_i) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops, except irq_o, an AND-OR of irq_stat and irq_mask
  assign cor_err_detect_o = st_reg.detect;
  assign cor_err_signal_o = st_reg.signal;
  assign crc_check_enable_o = st_reg.ctl[BIT_CHK_EN]; // [RULE3]
  assign crc_generate_enable_o = st_reg.ctl[BIT_GEN_EN]; // [RULE4]
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

  // Checks on the register core
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_sticky_i);

  mask_cold_reset_a: assert property ( // [RULE1]
    $past(rst_sticky_i) |-> st_reg.mask == 32'h0000_2000 && st_reg.mask[13])
    else $error("mask not at reset value after cold reset");

  mask_sticky_keep_a: assert property ( // [RULE1]
    rst_i && !rq.req |=> $stable(st_reg.mask))
    else $error("mask lost over ordinary reset");

  mask_reserved_zero_a: assert property ( // [RULE2]
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_COR_MASK |-> (wb_dat_o & 32'hffff_ce3e) == '0)
    else $error("reserved mask bits read non-zero");

  mask_write_bits_a: assert property ( // [RULE2]
    wr_hit && rq.adr == OFS_COR_MASK && rq.sel == 4'hf |=>
    st_reg.mask == ($past(rq.wdat) & 32'h0000_31c1))
    else $error("full mask write not stored");

  cap_read_ones_a: assert property ( // [RULE3]
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_CAP_CTRL |-> wb_dat_o[7] && wb_dat_o[5])
    else $error("capability bits not read as one");

  check_enable_out_a: assert property ( // [RULE3]
    wr_hit && rq.adr == OFS_CAP_CTRL && rq.sel[1] |=>
    crc_check_enable_o == $past(rq.wdat[8]))
    else $error("check enable not following write");

  gen_enable_out_a: assert property ( // [RULE4]
    wr_hit && rq.adr == OFS_CAP_CTRL && rq.sel[0] |=>
    crc_generate_enable_o == $past(rq.wdat[6]))
    else $error("generate enable not following write");

  cap_cold_reset_a: assert property ( // [RULE4]
    $past(rst_sticky_i) |-> ((st_reg.ctl & 32'h0000_0140) | 32'h0000_00a0) == 32'h0000_00a0)
    else $error("control not at reset value after cold reset");

  pointer_capture_a: assert property ( // [RULE5]
    capture_i && !st_reg.held |=> st_reg.ptr == $past(capture_bit_i) && st_reg.held)
    else $error("first error pointer not captured");

  pointer_frozen_a: assert property ( // [RULE5]
    st_reg.held && !log_release_i ##1 st_reg.held |-> $stable(st_reg.ptr) && $stable(st_reg.hdr0))
    else $error("logged error changed while held");

  header_capture_a: assert property ( // [RULE6]
    capture_i && !st_reg.held |=>
    st_reg.hdr0 == $past(capture_hdr_i[63:32]) && st_reg.hdr1 == $past(capture_hdr_i[31:0]))
    else $error("header not logged");

  bad_dllp_raise_a: assert property ( // [RULE7]
    dllp_valid_i && dllp_crc_calc_i != dllp_crc_rx_i && !rst_i |=> cor_err_detect_o[7])
    else $error("bad DLLP not raised on CRC mismatch");

  masked_quiet_a: assert property ( // [RULE8]
    (cor_now & st_reg.mask) != '0 && !rst_i |=>
    (cor_err_signal_o & $past(cor_now & st_reg.mask)) == '0 &&
    (cor_err_detect_o & $past(cor_now & st_reg.mask)) == $past(cor_now & st_reg.mask))
    else $error("masked error signalled or not recorded");

  irq_level_a: assert property (
    bad_dllp && !rst_i && st_reg.irq_mask[IRQ_BAD_DLLP] |=> irq_o)
    else $error("bad DLLP flag does not raise the interrupt");

  // A quiet read of the status register must leave no flag behind
  irq_read_clear_a: assert property (
    rd_hit && rq.adr == OFS_IRQ_STAT && !rst_i && !capture_i && !dllp_valid_i &&
    cor_err_i == '0 |=> st_reg.irq_stat == '0)
    else $error("interrupt flags not cleared by status read");

  header_logged_c: cover property (capture_i && !st_reg.held ##1 log_release_i);
  masked_error_c: cover property ((cor_now & st_reg.mask) != '0);
  bad_dllp_c: cover property (bad_dllp ##1 irq_o);
  sticky_survive_c: cover property (st_reg.ctl[BIT_CHK_EN] && rst_i);
endmodule

// ---- tb/test_pam_err_regs.sv ----
// Self-checking bench for the error mask, ECRC control and header log block.
// Assumes pam_pkg compiled first; one 100 MHz clock; bench is the bus master.
`timescale 1ns/100ps
module test_pam_err_regs;
  import pam_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i, rst_sticky_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [SEL_W-1:0] wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i, wb_dat_o, cor_err_i, cor_err_detect_o, cor_err_signal_o;
  logic dllp_valid_i, capture_i, log_release_i, crc_check_enable_o, crc_generate_enable_o, irq_o;
  logic [CRC_W-1:0] dllp_crc_calc_i, dllp_crc_rx_i;
  logic [PTR_W-1:0] capture_bit_i, ptr_m;
  logic [HDR_W-1:0] capture_hdr_i, hdr;
  logic [DAT_W-1:0] mask_m, ctl_m, hl0_m, hl1_m, rd, v;
  logic held_m;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h89cb;

  pam_err_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .rst_sticky_i(rst_sticky_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cor_err_i(cor_err_i), .dllp_valid_i(dllp_valid_i), .dllp_crc_calc_i(dllp_crc_calc_i),
    .dllp_crc_rx_i(dllp_crc_rx_i), .capture_i(capture_i), .capture_bit_i(capture_bit_i),
    .capture_hdr_i(capture_hdr_i), .log_release_i(log_release_i),
    .cor_err_detect_o(cor_err_detect_o), .cor_err_signal_o(cor_err_signal_o),
    .crc_check_enable_o(crc_check_enable_o), .crc_generate_enable_o(crc_generate_enable_o),
    .irq_o(irq_o));

  // Free-running core clock
  always #5 clk_i = ~clk_i;

  // Verdict in one place; the watchdog ends here too
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; waits for ack, only the watchdog ends a hang
  task automatic bus(input logic we, input logic [ADR_W-1:0] a, input logic [SEL_W-1:0] s,
                     input logic [DAT_W-1:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic chk_reg(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
    bus(1'b0, a, 4'hf, 32'h0);
    chk(rd, exp);
  endtask

  // Mask, control and both header log registers against the model, plus an unmapped hole and the enables
  task automatic chk_all();
    chk_reg(OFS_COR_MASK, mask_m);
    chk_reg(OFS_CAP_CTRL, ctl_m | CAP_CTRL_RO1 | {27'h0, ptr_m});
    chk_reg(OFS_HDR_LOG0, hl0_m);
    chk_reg(OFS_HDR_LOG1, hl1_m);
    chk_reg(12'h200, 32'h0);
    chk({31'h0, crc_check_enable_o}, {31'h0, ctl_m[BIT_CHK_EN]});
    chk({31'h0, crc_generate_enable_o}, {31'h0, ctl_m[BIT_GEN_EN]});
  endtask

  // Lane-gated write of the writable bits only
  function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] o, input logic [DAT_W-1:0] d,
                                             input logic [DAT_W-1:0] w, input logic [SEL_W-1:0] s);
    logic [DAT_W-1:0] l;
    l = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~(w & l)) | (d & w & l);
  endfunction

  // Error pulse or DLLP; outputs are looked at in their one valid cycle
  task automatic event_chk(input logic [DAT_W-1:0] e, input logic dv, input logic [CRC_W-1:0] c,
                           input logic [CRC_W-1:0] r);
    logic [DAT_W-1:0] x;
    x = e | {24'h0, dv && (c != r), 7'h0};
    @(posedge clk_i);
    cor_err_i <= e;
    dllp_valid_i <= dv;
    dllp_crc_calc_i <= c;
    dllp_crc_rx_i <= r;
    @(posedge clk_i);
    cor_err_i <= '0;
    dllp_valid_i <= 1'b0;
    @(posedge clk_i);
    chk(cor_err_detect_o, x);
    chk(cor_err_signal_o, x & ~mask_m);
  endtask

  task automatic capture(input logic [PTR_W-1:0] b, input logic [HDR_W-1:0] h, input logic rel);
    @(posedge clk_i);
    capture_i <= ~rel;
    log_release_i <= rel;
    capture_bit_i <= b;
    capture_hdr_i <= h;
    @(posedge clk_i);
    capture_i <= 1'b0;
    log_release_i <= 1'b0;
    if (rel) begin
      held_m = 1'b0;
    end else if (!held_m) begin
      held_m = 1'b1;
      ptr_m = b;
      hl0_m = h[63:32];
      hl1_m = h[31:0];
    end
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial begin
    {rst_i, rst_sticky_i} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, dllp_valid_i, capture_i, log_release_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, cor_err_i, dllp_crc_calc_i, dllp_crc_rx_i} = '0;
    {capture_bit_i, capture_hdr_i} = '0;
    mask_m = COR_MASK_RST;
    ctl_m = CAP_CTRL_RST & CAP_CTRL_WR;
    {hl0_m, hl1_m, ptr_m, held_m} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rst_sticky_i <= 1'b0;
    chk_all();
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      wb_sel_i <= (i == 0) ? 4'hf : 4'($random(seed));
      @(posedge clk_i);
      bus(1'b1, OFS_COR_MASK, wb_sel_i, v);
      mask_m = merge(mask_m, v, COR_MASK_WR, wb_sel_i);
      bus(1'b1, OFS_CAP_CTRL, 4'hf, ~v);
      ctl_m = merge(ctl_m, ~v, CAP_CTRL_WR, 4'hf);
      bus(1'b1, OFS_HDR_LOG0, 4'hf, v);
      chk_all();
      event_chk(v & COR_MASK_WR, 1'b0, 16'h0, 16'h0);
      hdr = {$random(seed), $random(seed)};
      event_chk(32'h0, 1'b1, hdr[15:0], (i % 2) ? hdr[15:0] : hdr[31:16]);
    end
    // Ordinary reset spares every sticky field
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_all();
    // First error is logged; later ones wait for release
    capture(5'd4, {$random(seed), $random(seed)}, 1'b0);
    capture(5'd18, {$random(seed), $random(seed)}, 1'b0);
    chk_all();
    capture(5'd0, 64'h0, 1'b1);
    capture(5'd31, {$random(seed), $random(seed)}, 1'b0);
    chk_all();
    // Interrupt: raised, cleared by reading status, then masked
    bus(1'b1, OFS_COR_MASK, 4'hf, 32'h0);
    mask_m = 32'h0;
    bus(1'b1, OFS_IRQ_MASK, 4'hf, 32'h7);
    chk_reg(OFS_IRQ_STAT, 32'h4);
    event_chk(32'h1, 1'b0, 16'h0, 16'h0);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    chk_reg(OFS_IRQ_STAT, 32'h1);
    chk_reg(OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    event_chk(32'h0, 1'b1, 16'h1, 16'h2);
    chk({31'h0, irq_o}, 32'h1);
    chk_reg(OFS_IRQ_STAT, 32'h3);
    bus(1'b1, OFS_IRQ_MASK, 4'hf, 32'h0);
    event_chk(32'h1, 1'b0, 16'h0, 16'h0);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    chk_reg(OFS_IRQ_STAT, 32'h1);
    complete_run();
  end
endmodule
